// *** hw/pfd_decoder.sv ***
// peripheral frame decoder: steers processor data accesses into three frames with write gating
//
// Overview of operation
// - frame 0 memory bus, 1 32-bit, 2 16-bit
// - frame 0 takes 16 and 32-bit accesses
// - protected writes blocked until unlock; reads free
// - lock instruction re-blocks protected writes
// - flash registers: writes need unlock and security lock release, reads only the release
// - key registers decoded, write protected
// - interrupt control open, vector table protected
// - external bus configuration decoded, unprotected
// - timer registers decoded, unprotected
// - flash registers one 96-word frame 0 region
// - can registers and mailbox RAM in frame 1
// - can region: per-bit protection via prot_ok
// - pin mux protected, pin data open
// - two serial port sets, unprotected
// - spi set decoded, unprotected
// - two motor event unit sets, unprotected
// - buffered serial port set, unprotected
// - frame 2 ignores 32-bit accesses
`timescale 1ns/1ps
`default_nettype none
module pfd_decoder
  import pfd_pkg::*;
(
  input  wire logic        CLK,              // system clock, 200 MHz
  input  wire logic        RST_B,            // asynchronous reset, active low
  input  wire logic        UNLOCK_EXEC,      // one-cycle pulse: unlock instruction executed
  input  wire logic        LOCK_EXEC,        // one-cycle pulse: lock instruction executed
  input  wire logic        SECURE_OPEN,      // code security lock released
  input  wire pfd_req_type CPU_REQ,          // processor access
  output pfd_periph_type   F0_BUS,           // frame 0 memory bus side
  output pfd_periph_type   F1_BUS,           // frame 1 32-bit bus side
  output pfd_periph_type   F2_BUS,           // frame 2 16-bit bus side
  input  wire logic [31:0] F0_RDATA,         // frame 0 read data
  input  wire logic [31:0] F1_RDATA,         // frame 1 read data
  input  wire logic [15:0] F2_RDATA,         // frame 2 read data
  output logic [31:0]      CPU_RDATA,        // registered read data
  output logic             CPU_RVALID,       // read data valid pulse
  output logic             UNLOCKED,         // protected-write window open
  output logic             WR_BLOCKED        // pulse: last write was dropped
);

  ////////////////////////////////////////////////////////////////////////////
  // decode

  logic           hit;                       // address fell into a region
  logic [4:0]     region;                    // its index
  pfd_region_type entry;                     // its attributes

  pfd_region_match u_match (
    .addr  (CPU_REQ.addr),
    .hit   (hit),
    .index (region),
    .entry (entry)
  );

  logic unlock_reg;                          // protected-write window state
  logic unlock_next;                         // its next value

  // frame selects from the matched entry
  wire in_f0 = hit && (entry.frame == FRM_ZERO);
  wire in_f1 = hit && (entry.frame == FRM_ONE);
  wire in_f2 = hit && (entry.frame == FRM_TWO);

  // 32-bit access into frame 2 is dropped entirely
  wire f2_width_bad = in_f2 && CPU_REQ.wide;

  // security gate applies to reads and writes of the flash block
  wire sec_bad = entry.secure && !SECURE_OPEN;

  // protected write without unlock; reads never blocked
  wire wprot_bad = CPU_REQ.write && entry.wprot && !unlock_reg;

  // final go for the access; reserved space never selects
  // the map's catch-all entry has no frame, so a hit on it must not count as a go
  wire go = CPU_REQ.valid && (in_f0 || in_f1 || in_f2) && !f2_width_bad && !sec_bad && !wprot_bad;

  // frame 0 and frame 1 take either width, no gating on it
  wire go_f0 = go && in_f0;
  wire go_f1 = go && in_f1;
  wire go_f2 = go && in_f2;

  // protection flag passed down; can registers apply it per bit
  wire prot_ok = unlock_reg;

  ////////////////////////////////////////////////////////////////////////////
  // protected-write window

  // lock wins when both arrive: safer to stay closed
  always_comb begin
    unlock_next = unlock_reg;
    if (LOCK_EXEC) begin
      unlock_next = 1'b0;
    end else if (UNLOCK_EXEC) begin
      unlock_next = 1'b1;
    end
  end

  // window register
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      unlock_reg <= UNLOCK_RST;
    end else begin
      unlock_reg <= unlock_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // peripheral side drives: combinational strobes, one per frame

  always_comb begin
    F0_BUS         = '0;
    F0_BUS.sel     = go_f0;
    F0_BUS.write   = CPU_REQ.write;
    F0_BUS.wide    = CPU_REQ.wide;
    F0_BUS.prot_ok = prot_ok;
    F0_BUS.region  = region;
    F0_BUS.addr    = CPU_REQ.addr;
    F0_BUS.wdata   = CPU_REQ.wdata;
  end

  // frame 1 carries the full 32-bit word
  always_comb begin
    F1_BUS         = '0;
    F1_BUS.sel     = go_f1;
    F1_BUS.write   = CPU_REQ.write;
    F1_BUS.wide    = CPU_REQ.wide;
    F1_BUS.prot_ok = prot_ok;
    F1_BUS.region  = region;
    F1_BUS.addr    = CPU_REQ.addr;
    F1_BUS.wdata   = CPU_REQ.wdata;
  end

  // frame 2 is 16 bits; upper half forced to zero
  always_comb begin
    F2_BUS         = '0;
    F2_BUS.sel     = go_f2;
    F2_BUS.write   = CPU_REQ.write;
    F2_BUS.prot_ok = prot_ok;
    F2_BUS.region  = region;
    F2_BUS.addr    = CPU_REQ.addr;
    F2_BUS.wdata   = {16'h0000, CPU_REQ.wdata[15:0]};
  end

  ////////////////////////////////////////////////////////////////////////////
  // read return

  wire rd_go = go && !CPU_REQ.write;         // accepted read
  wire rd_any = CPU_REQ.valid && !CPU_REQ.write;  // every read answers

  // 16-bit reads keep only the low half; refused reads give zero
  logic [31:0] rdata_mux;
  always_comb begin
    rdata_mux = 32'h0000_0000;
    if (rd_go && in_f0) begin
      rdata_mux = CPU_REQ.wide ? F0_RDATA : {16'h0000, F0_RDATA[15:0]};
    end else if (rd_go && in_f1) begin
      rdata_mux = CPU_REQ.wide ? F1_RDATA : {16'h0000, F1_RDATA[15:0]};
    end else if (rd_go && in_f2) begin
      rdata_mux = {16'h0000, F2_RDATA};
    end
  end

  wire wr_drop = CPU_REQ.valid && CPU_REQ.write && !go;  // refused write

  // read data and status, one cycle after the request
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      CPU_RDATA  <= 32'h0000_0000;
      CPU_RVALID <= 1'b0;
      WR_BLOCKED <= 1'b0;
    end else begin
      CPU_RDATA  <= rdata_mux;
      CPU_RVALID <= rd_any;
      WR_BLOCKED <= wr_drop;
    end
  end

  assign UNLOCKED = unlock_reg;

endmodule
`default_nettype wire

// *** hw/pfd_pkg.sv ***
// package: address map, region attributes and access carriers of the peripheral frame decoder
package pfd_pkg;

  // word address width of the processor data space
  localparam int unsigned ADDR_W = 22;

  // frame 0 region bounds (inclusive, 16-bit word addresses)
  localparam logic [21:0] EMU_LO    = 22'h000880;
  localparam logic [21:0] EMU_HI    = 22'h0009ff;
  localparam logic [21:0] FLASH_LO  = 22'h000a80;
  localparam logic [21:0] FLASH_HI  = 22'h000adf;
  localparam logic [21:0] KEY_LO    = 22'h000ae0;
  localparam logic [21:0] KEY_HI    = 22'h000aef;
  localparam logic [21:0] EXTBUS_LO = 22'h000b20;
  localparam logic [21:0] EXTBUS_HI = 22'h000b3f;
  localparam logic [21:0] TIMER_LO  = 22'h000c00;
  localparam logic [21:0] TIMER_HI  = 22'h000c3f;
  localparam logic [21:0] IRQX_LO   = 22'h000ce0;
  localparam logic [21:0] IRQX_HI   = 22'h000cff;
  localparam logic [21:0] VECT_LO   = 22'h000d00;
  localparam logic [21:0] VECT_HI   = 22'h000dff;

  // frame 1 region bounds
  localparam logic [21:0] CANREG_LO = 22'h006000;
  localparam logic [21:0] CANREG_HI = 22'h0060ff;
  localparam logic [21:0] CANMBX_LO = 22'h006100;
  localparam logic [21:0] CANMBX_HI = 22'h0061ff;

  // frame 2 region bounds
  localparam logic [21:0] SYSCTL_LO = 22'h007010;
  localparam logic [21:0] SYSCTL_HI = 22'h00702f;
  localparam logic [21:0] SPI_LO    = 22'h007040;
  localparam logic [21:0] SPI_HI    = 22'h00704f;
  localparam logic [21:0] UARTA_LO  = 22'h007050;
  localparam logic [21:0] UARTA_HI  = 22'h00705f;
  localparam logic [21:0] XIRQ_LO   = 22'h007070;
  localparam logic [21:0] XIRQ_HI   = 22'h00707f;
  localparam logic [21:0] PINMUX_LO = 22'h0070c0;
  localparam logic [21:0] PINMUX_HI = 22'h0070df;
  localparam logic [21:0] PINDAT_LO = 22'h0070e0;
  localparam logic [21:0] PINDAT_HI = 22'h0070ff;
  localparam logic [21:0] ADC_LO    = 22'h007100;
  localparam logic [21:0] ADC_HI    = 22'h00711f;
  localparam logic [21:0] MEVA_LO   = 22'h007400;
  localparam logic [21:0] MEVA_HI   = 22'h00743f;
  localparam logic [21:0] MEVB_LO   = 22'h007500;
  localparam logic [21:0] MEVB_HI   = 22'h00753f;
  localparam logic [21:0] UARTB_LO  = 22'h007750;
  localparam logic [21:0] UARTB_HI  = 22'h00775f;
  localparam logic [21:0] BMSP_LO   = 22'h007800;
  localparam logic [21:0] BMSP_HI   = 22'h00783f;

  // number of map entries: 20 decoded regions plus the catch-all entry at the end
  localparam int unsigned NREG = 21;

  // protection lock state after reset: writes to protected regions blocked
  localparam logic UNLOCK_RST = 1'b0;

  // frame codes
  typedef enum logic [1:0] {
    FRM_NONE_type_e = 2'h0,
    FRM_ZERO        = 2'h1,
    FRM_ONE         = 2'h2,
    FRM_TWO         = 2'h3
  } pfd_frame_type;

  // one region entry of the map
  typedef struct packed {
    logic [21:0]   lo;        // first word
    logic [21:0]   hi;        // last word
    pfd_frame_type frame;     // frame it lives in
    logic          wprot;     // writes need unlock
    logic          secure;    // also gated by the security lock
    logic          canctl;    // bit-selective protection region
  } pfd_region_type;

  // processor side access request
  typedef struct packed {
    logic        valid;       // access strobe
    logic        write;       // 1 write, 0 read
    logic        wide;        // 1 for 32-bit, 0 for 16-bit
    logic [21:0] addr;        // word address
    logic [31:0] wdata;       // write data, low word first
  } pfd_req_type;

  // peripheral side access towards one frame
  typedef struct packed {
    logic        sel;         // peripheral select
    logic        write;       // write strobe qualifier
    logic        wide;        // 32-bit access
    logic        prot_ok;     // unlock held, protected bits writable
    logic [4:0]  region;      // region index inside the map
    logic [21:0] addr;        // word address
    logic [31:0] wdata;       // write data
  } pfd_periph_type;

  // region table
  localparam pfd_region_type REGION_MAP [NREG] = '{
    '{EMU_LO,    EMU_HI,    FRM_ZERO, 1'b1, 1'b0, 1'b0},
    '{FLASH_LO,  FLASH_HI,  FRM_ZERO, 1'b1, 1'b1, 1'b0},
    '{KEY_LO,    KEY_HI,    FRM_ZERO, 1'b1, 1'b0, 1'b0},
    '{EXTBUS_LO, EXTBUS_HI, FRM_ZERO, 1'b0, 1'b0, 1'b0},
    '{TIMER_LO,  TIMER_HI,  FRM_ZERO, 1'b0, 1'b0, 1'b0},
    '{IRQX_LO,   IRQX_HI,   FRM_ZERO, 1'b0, 1'b0, 1'b0},
    '{VECT_LO,   VECT_HI,   FRM_ZERO, 1'b1, 1'b0, 1'b0},
    '{CANREG_LO, CANREG_HI, FRM_ONE,  1'b0, 1'b0, 1'b1},
    '{CANMBX_LO, CANMBX_HI, FRM_ONE,  1'b0, 1'b0, 1'b0},
    '{SYSCTL_LO, SYSCTL_HI, FRM_TWO,  1'b1, 1'b0, 1'b0},
    '{SPI_LO,    SPI_HI,    FRM_TWO,  1'b0, 1'b0, 1'b0},
    '{UARTA_LO,  UARTA_HI,  FRM_TWO,  1'b0, 1'b0, 1'b0},
    '{XIRQ_LO,   XIRQ_HI,   FRM_TWO,  1'b0, 1'b0, 1'b0},
    '{PINMUX_LO, PINMUX_HI, FRM_TWO,  1'b1, 1'b0, 1'b0},
    '{PINDAT_LO, PINDAT_HI, FRM_TWO,  1'b0, 1'b0, 1'b0},
    '{ADC_LO,    ADC_HI,    FRM_TWO,  1'b0, 1'b0, 1'b0},
    '{MEVA_LO,   MEVA_HI,   FRM_TWO,  1'b0, 1'b0, 1'b0},
    '{MEVB_LO,   MEVB_HI,   FRM_TWO,  1'b0, 1'b0, 1'b0},
    '{UARTB_LO,  UARTB_HI,  FRM_TWO,  1'b0, 1'b0, 1'b0},
    '{BMSP_LO,   BMSP_HI,   FRM_TWO,  1'b0, 1'b0, 1'b0},
    '{22'h3fffff, 22'h3fffff, FRM_NONE_type_e, 1'b0, 1'b0, 1'b0}
  };

endpackage

// *** hw/pfd_region_match.sv ***
// region matcher: finds the map entry that holds an address
`timescale 1ns/1ps
`default_nettype none
module pfd_region_match
  import pfd_pkg::*;
(
  input  wire logic [21:0] addr,      // word address under test
  output logic             hit,       // some region matched
  output logic [4:0]       index,     // matching region index
  output pfd_region_type   entry      // attributes of the match
);

  logic [NREG-1:0] match_vec;         // one bit per region

  // one comparator pair per region
  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_cmp
      assign match_vec[g] = (addr >= REGION_MAP[g].lo) && (addr <= REGION_MAP[g].hi);
    end
  endgenerate

  // regions never overlap, so a priority pick is only a one-hot encode
  always_comb begin
    hit   = 1'b0;
    index = 5'h00;
    entry = REGION_MAP[NREG-1];
    for (int i = 0; i < NREG; i++) begin
      if (match_vec[i] && !hit) begin
        hit   = 1'b1;
        index = 5'(i);
        entry = REGION_MAP[i];
      end
    end
  end

endmodule
`default_nettype wire

// *** sim/pfd_monitor.sv ***
// checker: timing and gating of the frame decoder seen at its ports
`timescale 1ns/1ps
`default_nettype none
module pfd_monitor
  import pfd_pkg::*;
(
  input wire logic           CLK,
  input wire logic           RST_B,
  input wire logic           UNLOCK_EXEC,
  input wire logic           LOCK_EXEC,
  input wire logic           SECURE_OPEN,
  input wire pfd_req_type    CPU_REQ,
  input wire pfd_periph_type F0_BUS,
  input wire pfd_periph_type F1_BUS,
  input wire pfd_periph_type F2_BUS,
  input wire logic [31:0]    CPU_RDATA,
  input wire logic           CPU_RVALID,
  input wire logic           UNLOCKED,
  input wire logic           WR_BLOCKED
);
  ////////////////////////////////////////////////////////////////
  // request classes, decoded here on purpose, not taken from the design
  wire logic [21:0] a      = CPU_REQ.addr;
  wire logic        rd     = CPU_REQ.valid && !CPU_REQ.write;
  wire logic        wr     = CPU_REQ.valid && CPU_REQ.write;
  wire logic        in_f2  = a >= 22'h007000 && a <= 22'h007fff;
  wire logic        in_key = a >= KEY_LO && a <= KEY_HI;
  wire logic        in_fl  = a >= FLASH_LO && a <= FLASH_HI;
  wire logic        in_rsv = a >= 22'h000a00 && a <= 22'h000a7f;
  wire logic        in_tmr = a >= TIMER_LO && a <= TIMER_HI;
  wire logic        in_can = a >= CANREG_LO && a <= CANREG_HI;
  wire logic        any    = F0_BUS.sel || F1_BUS.sel || F2_BUS.sel;
  ////////////////////////////////////////////////////////////////
  // one clock domain: shared clock and reset
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  chk_read_answer: assert property (rd |=> CPU_RVALID) else $error("read not answered");
  chk_one_select: assert property ($onehot0({F0_BUS.sel, F1_BUS.sel, F2_BUS.sel})) else $error("two selects");
  chk_timer_width: assert property (CPU_REQ.valid && in_tmr |-> F0_BUS.sel && F0_BUS.wide == CPU_REQ.wide)
    else $error("timer access not passed");
  chk_key_locked: assert property (wr && in_key && !UNLOCKED |-> !F0_BUS.sel ##1 WR_BLOCKED)
    else $error("locked key write passed");
  chk_lock_wins: assert property (LOCK_EXEC |=> !UNLOCKED) else $error("lock ignored");
  chk_unlock_holds: assert property (UNLOCKED && !LOCK_EXEC |=> UNLOCKED) else $error("unlock lost");
  chk_flash_secure: assert property (CPU_REQ.valid && in_fl && !SECURE_OPEN |-> !any)
    else $error("secured flash selected");
  chk_timer_open: assert property (wr && in_tmr |=> !WR_BLOCKED) else $error("open write blocked");
  chk_can_prot: assert property (F1_BUS.sel && in_can |-> F1_BUS.prot_ok == UNLOCKED)
    else $error("can prot_ok wrong");
  chk_f2_wide: assert property (CPU_REQ.valid && CPU_REQ.wide && in_f2 |-> !F2_BUS.sel)
    else $error("wide frame two access passed");
  chk_rsv_zero: assert property (rd && in_rsv |-> !any ##1 CPU_RDATA == 32'h0)
    else $error("reserved read not zero");
  // main scenarios reached
  cov_key_unlocked: cover property (wr && in_key && UNLOCKED);
  cov_f2_read: cover property (rd && in_f2);
  cov_lock: cover property (LOCK_EXEC);
endmodule
bind pfd_decoder pfd_monitor pfd_monitor_inst (.CLK(CLK), .RST_B(RST_B), .UNLOCK_EXEC(UNLOCK_EXEC),
  .LOCK_EXEC(LOCK_EXEC), .SECURE_OPEN(SECURE_OPEN), .CPU_REQ(CPU_REQ), .F0_BUS(F0_BUS), .F1_BUS(F1_BUS),
  .F2_BUS(F2_BUS), .CPU_RDATA(CPU_RDATA), .CPU_RVALID(CPU_RVALID), .UNLOCKED(UNLOCKED), .WR_BLOCKED(WR_BLOCKED));
`default_nettype wire

// *** sim/pfd_periph_model.sv ***
// partner model: peripheral register blocks answering on the three frames
`timescale 1ns/1ps
`default_nettype none
module pfd_periph_model
  import pfd_pkg::*;
(
  input  wire pfd_periph_type F0_BUS,
  input  wire pfd_periph_type F1_BUS,
  input  wire pfd_periph_type F2_BUS,
  output logic [31:0]         F0_RDATA,
  output logic [31:0]         F1_RDATA,
  output logic [15:0]         F2_RDATA
);
  ////////////////////////////////////////////////////////////////
  // data is a fixed function of the address; unselected frames show the inverse so stale data cannot pass
  wire logic [15:0] a0 = F0_BUS.addr[15:0];
  wire logic [15:0] a1 = F1_BUS.addr[15:0];
  wire logic [15:0] a2 = F2_BUS.addr[15:0];
  assign F0_RDATA = F0_BUS.sel ? {a0 ^ 16'h5a5a, a0} : ~{a0 ^ 16'h5a5a, a0};
  assign F1_RDATA = F1_BUS.sel ? {a1 ^ 16'h5a5a, a1} : ~{a1 ^ 16'h5a5a, a1};
  // 16-bit bus: only the low half exists
  assign F2_RDATA = F2_BUS.sel ? a2 ^ 16'hc3c3 : ~(a2 ^ 16'hc3c3);
endmodule
`default_nettype wire

// *** sim/tb.sv ***
// testbench: routing, protection, security and width gating of the frame decoder
`timescale 1ns/1ps
`default_nettype none
module tb
  import pfd_pkg::*;
;
  logic CLK = 1'b0, RST_B = 1'b0, UNLOCK_EXEC = 1'b0, LOCK_EXEC = 1'b0, SECURE_OPEN = 1'b0;
  pfd_req_type    CPU_REQ = '0;
  pfd_periph_type F0_BUS, F1_BUS, F2_BUS;
  logic [31:0]    F0_RDATA, F1_RDATA, CPU_RDATA;
  logic [15:0]    F2_RDATA;
  logic           CPU_RVALID, UNLOCKED, WR_BLOCKED;
  int             n_fail = 0, comparisons = 0, cycles = 0;
  pfd_decoder pfd_decoder_inst (.CLK(CLK), .RST_B(RST_B), .UNLOCK_EXEC(UNLOCK_EXEC), .LOCK_EXEC(LOCK_EXEC),
    .SECURE_OPEN(SECURE_OPEN), .CPU_REQ(CPU_REQ), .F0_BUS(F0_BUS), .F1_BUS(F1_BUS), .F2_BUS(F2_BUS),
    .F0_RDATA(F0_RDATA), .F1_RDATA(F1_RDATA), .F2_RDATA(F2_RDATA), .CPU_RDATA(CPU_RDATA),
    .CPU_RVALID(CPU_RVALID), .UNLOCKED(UNLOCKED), .WR_BLOCKED(WR_BLOCKED));
  pfd_periph_model pfd_periph_model_inst (.F0_BUS(F0_BUS), .F1_BUS(F1_BUS), .F2_BUS(F2_BUS),
    .F0_RDATA(F0_RDATA), .F1_RDATA(F1_RDATA), .F2_RDATA(F2_RDATA));
  ////////////////////////////////////////////////////////////////
  // 200 MHz clock; hang guard far above the roughly 110 cycles needed
  initial forever #2.5 CLK = ~CLK;
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (n_fail == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  // one access: select in its cycle, answer one cycle later; refused reads give zero
  task automatic acc(input logic wr, input logic wd, input logic [21:0] a, input logic ok);
    logic [1:0]  fr;
    logic [31:0] e;
    fr = (a < 22'h006000) ? 2'd0 : (a < 22'h007000) ? 2'd1 : 2'd2;
    e = (fr == 2'd2) ? {16'h0, a[15:0] ^ 16'hc3c3} : {a[15:0] ^ 16'h5a5a, a[15:0]};
    if (!wd) e[31:16] = 16'h0;
    if (!ok) e = 32'h0;
    @(posedge CLK);
    CPU_REQ <= '{1'b1, wr, wd, a, {~a[15:0], a[15:0]}};
    @(negedge CLK);
    chk("f0_sel", F0_BUS.sel, ok && fr == 2'd0);
    chk("f1_sel", F1_BUS.sel, ok && fr == 2'd1);
    chk("f2_sel", F2_BUS.sel, ok && fr == 2'd2);
    if (ok && fr == 2'd1) chk("f1_wdata", F1_BUS.wdata, {~a[15:0], a[15:0]});
    if (ok && fr == 2'd2) chk("f2_wdata", F2_BUS.wdata, {16'h0000, a[15:0]});
    @(posedge CLK);
    CPU_REQ <= '0;
    @(negedge CLK);
    chk("rvalid", CPU_RVALID, !wr);
    if (!wr) chk("rdata", CPU_RDATA, e);
    chk("wr_blocked", WR_BLOCKED, wr && !ok);
  endtask
  // one-cycle unlock or lock pulse, window state checked after it lands
  task automatic pulse(input logic unl);
    @(posedge CLK);
    if (unl) UNLOCK_EXEC <= 1'b1;
    else LOCK_EXEC <= 1'b1;
    @(posedge CLK);
    UNLOCK_EXEC <= 1'b0;
    LOCK_EXEC <= 1'b0;
    @(negedge CLK);
    chk("unlocked", UNLOCKED, unl);
  endtask
  ////////////////////////////////////////////////////////////////
  // decoded regions reached while locked, all but EMU, FLASH, SYSCTL, XIRQ, PINMUX and ADC; frame 0 at both widths
  task automatic t_map();
    logic [21:0] ad [14];
    ad = '{22'h000b20, 22'h000c3f, 22'h000ce0, 22'h000d00, 22'h000ae0, 22'h006000, 22'h006100,
           22'h007040, 22'h007050, 22'h007750, 22'h007400, 22'h00753f, 22'h00783f, 22'h0070e0};
    for (int i = 0; i < 14; i++) begin
      acc(1'b0, ad[i] < 22'h007000 && (ad[i] >= 22'h006000 || i % 2 == 1), ad[i], 1'b1);
    end
    acc(1'b1, 1'b1, 22'h000c00, 1'b1);
    acc(1'b1, 1'b0, 22'h000cff, 1'b1);
    acc(1'b1, 1'b1, 22'h0061fe, 1'b1);
    acc(1'b1, 1'b0, 22'h0070ff, 1'b1);
    acc(1'b1, 1'b1, 22'h000b3e, 1'b1);
  endtask
  // protected writes refused, opened by unlock, shut again by lock
  task automatic t_prot();
    acc(1'b1, 1'b0, 22'h000ae0, 1'b0);
    acc(1'b1, 1'b1, 22'h000dfe, 1'b0);
    acc(1'b1, 1'b0, 22'h0070c0, 1'b0);
    pulse(1'b1);
    acc(1'b1, 1'b0, 22'h000aef, 1'b1);
    acc(1'b1, 1'b1, 22'h000d00, 1'b1);
    acc(1'b1, 1'b0, 22'h0070df, 1'b1);
    acc(1'b1, 1'b1, 22'h006002, 1'b1);
    pulse(1'b0);
    acc(1'b1, 1'b0, 22'h000ae5, 1'b0);
  endtask
  // flash writes need both the security release and the unlock; reads need only the release
  task automatic t_secure();
    acc(1'b0, 1'b1, 22'h000a80, 1'b0);
    pulse(1'b1);
    acc(1'b1, 1'b0, 22'h000adf, 1'b0);
    @(posedge CLK);
    SECURE_OPEN <= 1'b1;
    acc(1'b1, 1'b1, 22'h000a90, 1'b1);
    pulse(1'b0);
    acc(1'b0, 1'b0, 22'h000adf, 1'b1);
    acc(1'b1, 1'b0, 22'h000a80, 1'b0);
  endtask
  // wide accesses to the 16-bit frame are refused
  task automatic t_f2wide();
    acc(1'b0, 1'b1, 22'h007040, 1'b0);
    acc(1'b1, 1'b1, 22'h007750, 1'b0);
  endtask
  // holes between regions select nothing
  task automatic t_reserved();
    acc(1'b0, 1'b0, 22'h000a00, 1'b0);
    acc(1'b0, 1'b1, 22'h006200, 1'b0);
    acc(1'b1, 1'b0, 22'h007030, 1'b0);
    acc(1'b0, 1'b0, 22'h000b40, 1'b0);
  endtask
  // reset in mid-run closes the unlock window
  task automatic t_reset();
    pulse(1'b1);
    // lock and unlock in one cycle: lock must win
    @(posedge CLK);
    UNLOCK_EXEC <= 1'b1;
    LOCK_EXEC <= 1'b1;
    @(posedge CLK);
    UNLOCK_EXEC <= 1'b0;
    LOCK_EXEC <= 1'b0;
    @(negedge CLK);
    chk("both_locked", UNLOCKED, 1'b0);
    pulse(1'b1);
    @(posedge CLK);
    RST_B <= 1'b0;
    @(negedge CLK);
    chk("rst_unlocked", UNLOCKED, 1'b0);
    @(posedge CLK);
    RST_B <= 1'b1;
    acc(1'b1, 1'b0, 22'h000ae0, 1'b0);
  endtask
  initial begin
    repeat (16) @(posedge CLK);
    RST_B <= 1'b1;
    t_map();
    t_prot();
    t_secure();
    t_f2wide();
    t_reserved();
    t_reset();
    complete_run();
  end
endmodule
`default_nettype wire
